// ==== rtl/rsc_rx_clk_rst.sv ====
// Receiver clock recovery, per-lane reset status and link reset sequencing
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - Link-domain logic is reset by one active-low link reset input.
// - One recovered clock per lane is output, derived from the data recovery circuit; here each follows link_clk_in while its lane is in lock-to-data.
// - With hard or soft PCS each recovered clock has the link clock frequency.
// - With PMA direct each recovered clock runs at half the link clock frequency.
// - A lane's PCS is held in reset while its PCS reset input is high.
// - A lane's data recovery and PMA are held in reset while its analog reset is high.
// - Each lane reports its PCS reset state to the reset controller.
// - Each lane reports its PMA reset state to the reset controller.
// - Each lane flags lock once it has moved from lock-to-reference to lock-to-data.
// - Each lane holds calibration busy high while its calibration runs.
// - Each lane takes differential serial data and recovers its clock from it; here the data feeds lock detection and PCS words; the clock follows link_clk_in.
// - 46 bits per lane of reconfiguration status go back to that controller.
module rsc_rx_clk_rst (
    input  wire logic                                   aclk,              // 20 MHz clock
    input  wire logic                                   aresetn,           // Sync reset, low
    input  wire logic [31:0]                            s_axi_awaddr,      // Write address
    input  wire logic                                   s_axi_awvalid,     // Write addr valid
    output logic                                        s_axi_awready,     // Write addr ready
    input  wire logic [31:0]                            s_axi_wdata,       // Write data
    input  wire logic [3:0]                             s_axi_wstrb,       // Byte enables
    input  wire logic                                   s_axi_wvalid,      // Write data valid
    output logic                                        s_axi_wready,      // Write data ready
    output logic [1:0]                                  s_axi_bresp,       // Write response
    output logic                                        s_axi_bvalid,      // Write resp valid
    input  wire logic                                   s_axi_bready,      // Write resp ready
    input  wire logic [31:0]                            s_axi_araddr,      // Read address
    input  wire logic                                   s_axi_arvalid,     // Read addr valid
    output logic                                        s_axi_arready,     // Read addr ready
    output logic [31:0]                                 s_axi_rdata,       // Read data
    output logic [1:0]                                  s_axi_rresp,       // Read response
    output logic                                        s_axi_rvalid,      // Read data valid
    input  wire logic                                   s_axi_rready,      // Read data ready
    input  wire logic                                   link_clk_in,       // Link clock, sampled
    input  wire logic                                   link_rst_n,        // Link reset, low
    output logic                                        link_rx_rst_n,     // Link logic reset
    input  wire logic [rsc_pkg::LANES-1:0]              serial_p,          // Serial data +
    input  wire logic [rsc_pkg::LANES-1:0]              serial_n,          // Serial data -
    output logic [rsc_pkg::LANES-1:0]                   rec_clk,           // Recovered clocks
    input  wire logic [rsc_pkg::LANES-1:0]              pcs_reset,         // PCS reset, high
    input  wire logic [rsc_pkg::LANES-1:0]              analog_reset,      // PMA reset, high
    output logic [rsc_pkg::LANES-1:0]                   pcs_reset_stat,    // PCS reset state
    output logic [rsc_pkg::LANES-1:0]                   pma_reset_stat,    // PMA reset state
    output logic [rsc_pkg::LANES-1:0]                   lock_to_data,      // Lane locked
    output logic [rsc_pkg::LANES-1:0]                   cal_busy,          // Calibrating
    input  wire logic [rsc_pkg::LANES*rsc_pkg::RCFG_IN_W-1:0]  reconfig_bus_in,  // Reconfig in
    output logic [rsc_pkg::LANES*rsc_pkg::RCFG_OUT_W-1:0] reconfig_bus_out  // Reconfig out
);
    localparam int L = rsc_pkg::LANES;

    rsc_pkg::rsc_lane_e        lane_st_r   [L];
    logic [rsc_pkg::CNT_W-1:0] lane_cnt_r  [L];
    logic [rsc_pkg::PCS_W-1:0] pcs_word_r  [L];
    logic [L-1:0]              ser_d_r;
    logic                      link_clk_d_r;
    logic [L-1:0]              lane_en_r;
    logic                      pma_direct_r;
    rsc_pkg::rsc_lane_stat_s   lane_stat   [L];

    logic                      aw_got_r;
    logic                      w_got_r;
    logic [31:0]               awaddr_r;
    logic [31:0]               wdata_r;
    logic [3:0]                wstrb_r;

    function automatic rsc_pkg::rsc_reg_e reg_decode(input logic [31:0] addr);
        if (addr == rsc_pkg::CTRL_OFFSET) begin
            return rsc_pkg::REG_CTRL;
        end else if (addr == rsc_pkg::STATUS_OFFSET) begin
            return rsc_pkg::REG_STATUS;
        end
        return rsc_pkg::REG_NONE;
    endfunction

    // A disabled lane never holds the link back
    function automatic logic lanes_ready(input logic [L-1:0] en, input logic [L-1:0] lk,
                                         input logic [L-1:0] bz, input logic [L-1:0] ps,
                                         input logic [L-1:0] pm);
        return &(~en | (lk & ~bz & ~ps & ~pm));
    endfunction

    always_comb begin
        for (int i = 0; i < L; i++) begin
            lane_stat[i] = '{cal_busy: cal_busy[i], locked: lock_to_data[i],
                             pcs_stat: pcs_reset_stat[i], pma_stat: pma_reset_stat[i]};
        end
    end

    // Lane sequencer: reset, calibrate, lock to reference, then lock to data
    always_ff @(posedge aclk) begin
        for (int i = 0; i < L; i++) begin
            if (!aresetn || analog_reset[i]) begin
                lane_st_r[i]  <= rsc_pkg::LN_RESET;
                lane_cnt_r[i] <= '0;
            end else begin
                case (lane_st_r[i])
                    rsc_pkg::LN_RESET: begin
                        lane_st_r[i]  <= rsc_pkg::LN_CAL;
                        lane_cnt_r[i] <= '0;
                    end
                    rsc_pkg::LN_CAL: begin
                        if (lane_cnt_r[i] == rsc_pkg::CNT_W'(rsc_pkg::CAL_CYCLES - 1)) begin
                            lane_st_r[i]  <= rsc_pkg::LN_REF_LOCK;
                            lane_cnt_r[i] <= '0;
                        end else begin
                            lane_cnt_r[i] <= lane_cnt_r[i] + 1'b1;
                        end
                    end
                    rsc_pkg::LN_REF_LOCK: begin
                        // Count valid differential transitions in the data stream
                        if ((serial_p[i] != serial_n[i]) && (serial_p[i] != ser_d_r[i])) begin
                            if (lane_cnt_r[i] == rsc_pkg::CNT_W'(rsc_pkg::LOCK_EDGES - 1)) begin
                                lane_st_r[i] <= rsc_pkg::LN_LTD;
                            end
                            lane_cnt_r[i] <= lane_cnt_r[i] + 1'b1;
                        end
                    end
                    rsc_pkg::LN_LTD: begin
                        lane_st_r[i] <= rsc_pkg::LN_LTD;
                    end
                    default: begin
                        lane_st_r[i] <= rsc_pkg::LN_RESET;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser_d_r      <= '0;
            link_clk_d_r <= 1'b0;
        end else begin
            ser_d_r      <= serial_p;
            link_clk_d_r <= link_clk_in;
        end
    end

    // Lane status flags, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pcs_reset_stat <= '0;
            pma_reset_stat <= '0;
            lock_to_data   <= '0;
            cal_busy       <= '0;
        end else begin
            pcs_reset_stat <= pcs_reset;
            pma_reset_stat <= analog_reset;
            for (int i = 0; i < L; i++) begin
                lock_to_data[i] <= !analog_reset[i] && lane_st_r[i] == rsc_pkg::LN_LTD;
                cal_busy[i]     <= !analog_reset[i] && lane_st_r[i] == rsc_pkg::LN_CAL;
            end
        end
    end

    // Recovered clocks run only while locked; the fabric clock bounds their rate
    always_ff @(posedge aclk) begin
        for (int i = 0; i < L; i++) begin
            // Stop at once on PMA reset, not a cycle later when the state has left lock
            if (!aresetn || analog_reset[i] || lane_st_r[i] != rsc_pkg::LN_LTD) begin
                rec_clk[i] <= 1'b0;
            end else if (pma_direct_r) begin
                if (link_clk_in && !link_clk_d_r) begin
                    rec_clk[i] <= ~rec_clk[i];
                end
            end else begin
                rec_clk[i] <= link_clk_in;
            end
        end
    end

    // PCS word capture, cleared while the PCS is in reset
    always_ff @(posedge aclk) begin
        for (int i = 0; i < L; i++) begin
            if (!aresetn || pcs_reset[i]) begin
                pcs_word_r[i] <= '0;
            end else if (lane_st_r[i] == rsc_pkg::LN_LTD) begin
                pcs_word_r[i] <= {pcs_word_r[i][rsc_pkg::PCS_W-2:0], serial_p[i]};
            end
        end
    end

    // Status back to the reconfiguration controller, present in every mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reconfig_bus_out <= '0;
        end else begin
            for (int i = 0; i < L; i++) begin
                reconfig_bus_out[i*rsc_pkg::RCFG_OUT_W +: rsc_pkg::RCFG_OUT_W] <=
                    {lane_stat[i], pcs_word_r[i],
                     reconfig_bus_in[i*rsc_pkg::RCFG_IN_W +: 34]};
            end
        end
    end

    // Link reset: released only once all enabled lanes are usable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_rx_rst_n <= 1'b0;
        end else begin
            link_rx_rst_n <= link_rst_n &&
                lanes_ready(lane_en_r, lock_to_data, cal_busy, pcs_reset_stat,
                            pma_reset_stat);
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= rsc_pkg::RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r      <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (reg_decode(awaddr_r) == rsc_pkg::REG_NONE) ?
                                rsc_pkg::RESP_SLVERR : rsc_pkg::RESP_OKAY;
            end
            // Ready stays low until the response is taken, one write at a time
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Control register: lane enables in byte 0, PCS mode in byte 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lane_en_r    <= rsc_pkg::CTRL_LANE_EN_RST;
            pma_direct_r <= rsc_pkg::CTRL_PMA_DIRECT_RST;
        end else if (aw_got_r && w_got_r && !s_axi_bvalid &&
                     reg_decode(awaddr_r) == rsc_pkg::REG_CTRL) begin
            if (wstrb_r[0]) begin
                lane_en_r <= wdata_r[rsc_pkg::CTRL_LANE_EN_LSB +: L];
            end
            if (wstrb_r[1]) begin
                pma_direct_r <= wdata_r[rsc_pkg::CTRL_PMA_DIRECT_BIT];
            end
        end
    end

    // AXI4-Lite read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= rsc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= rsc_pkg::RESP_OKAY;
            case (reg_decode(s_axi_araddr))
                rsc_pkg::REG_CTRL: begin
                    s_axi_rdata[rsc_pkg::CTRL_LANE_EN_LSB +: L]  <= lane_en_r;
                    s_axi_rdata[rsc_pkg::CTRL_PMA_DIRECT_BIT]    <= pma_direct_r;
                end
                rsc_pkg::REG_STATUS: begin
                    s_axi_rdata[rsc_pkg::STAT_LOCK_LSB +: L] <= lock_to_data;
                    s_axi_rdata[rsc_pkg::STAT_BUSY_LSB +: L] <= cal_busy;
                    s_axi_rdata[rsc_pkg::STAT_PCS_LSB +: L]  <= pcs_reset_stat;
                    s_axi_rdata[rsc_pkg::STAT_PMA_LSB +: L]  <= pma_reset_stat;
                    s_axi_rdata[rsc_pkg::STAT_LINK_BIT]      <= link_rx_rst_n;
                end
                default: begin
                    s_axi_rresp <= rsc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_link_rst;
        !link_rst_n |=> !link_rx_rst_n;
    endproperty
    a_link_rst: assert property (p_link_rst) else $error("link reset not held");

    property p_link_rel;
        $rose(link_rx_rst_n) |-> $past(lanes_ready(lane_en_r, lock_to_data, cal_busy,
                                                   pcs_reset_stat, pma_reset_stat));
    endproperty
    a_link_rel: assert property (p_link_rel) else $error("link released early");

    property p_pma_hold;
        analog_reset[0] |=> !lock_to_data[0] && !cal_busy[0] && !rec_clk[0];
    endproperty
    a_pma_hold: assert property (p_pma_hold) else $error("lane active in pma reset");

    property p_cal_len;
        $rose(cal_busy[0]) && !analog_reset[0] |-> cal_busy[0] [*8];
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration too short");

    property p_lock_order;
        $rose(lock_to_data[0]) |-> $past(lane_st_r[0] == rsc_pkg::LN_REF_LOCK, 2);
    endproperty
    a_lock_order: assert property (p_lock_order) else $error("lock not from reference");

    property p_pcs_stat;
        aresetn && pcs_reset[0] |=> pcs_reset_stat[0] && pcs_word_r[0] == '0;
    endproperty
    a_pcs_stat: assert property (p_pcs_stat) else $error("pcs reset not shown");

    property p_pma_stat;
        $fell(analog_reset[0]) |=> !pma_reset_stat[0] ##1 cal_busy[0];
    endproperty
    a_pma_stat: assert property (p_pma_stat) else $error("pma release not shown");

    property p_same_freq;
        $past(aresetn && !analog_reset[0] && lane_st_r[0] == rsc_pkg::LN_LTD && !pma_direct_r) |->
            rec_clk[0] == $past(link_clk_in);
    endproperty
    a_same_freq: assert property (p_same_freq) else $error("rec clock not at link rate");

    property p_half_freq;
        $past(aresetn && !analog_reset[0] && lane_st_r[0] == rsc_pkg::LN_LTD && pma_direct_r &&
              link_clk_in && !link_clk_d_r)
            |-> rec_clk[0] != $past(rec_clk[0]);
    endproperty
    a_half_freq: assert property (p_half_freq) else $error("rec clock not halved");

    property p_rcfg_out;
        ##1 reconfig_bus_out[rsc_pkg::RCFG_OUT_W-2] == $past(lock_to_data[0]);
    endproperty
    a_rcfg_out: assert property (p_rcfg_out) else $error("reconfig status stale");

    c_lock:     cover property ($rose(lock_to_data[0]));
    c_link_up:  cover property ($rose(link_rx_rst_n));
    c_half_clk: cover property (pma_direct_r && $rose(rec_clk[0]));
    c_axi_err:  cover property (s_axi_bvalid && s_axi_bresp == rsc_pkg::RESP_SLVERR);
endmodule

// ==== rtl/rsc_pkg.sv ====
// Package for the serial receiver clock, reset and status block
package rsc_pkg;
    localparam int LANES          = 4;
    localparam int RCFG_IN_W      = 70;
    localparam int RCFG_OUT_W     = 46;
    localparam int CLK_PERIOD_NS  = 50;
    // Calibration after PMA reset release: at least this long
    localparam int CAL_TIME_NS    = 1000;
    localparam int CAL_CYCLES     = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Serial data transitions seen in lock-to-reference before lock-to-data
    localparam int LOCK_EDGES     = 8;
    localparam int CNT_W          = 5;
    localparam int PCS_W          = 8;

    localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
    localparam int CTRL_LANE_EN_LSB       = 0;
    localparam int CTRL_PMA_DIRECT_BIT    = 8;
    localparam logic [3:0] CTRL_LANE_EN_RST = 4'hf;
    localparam logic       CTRL_PMA_DIRECT_RST = 1'b0;
    localparam int STAT_LOCK_LSB  = 0;
    localparam int STAT_BUSY_LSB  = 4;
    localparam int STAT_PCS_LSB   = 8;
    localparam int STAT_PMA_LSB   = 12;
    localparam int STAT_LINK_BIT  = 16;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        REG_CTRL   = 2'b00,
        REG_STATUS = 2'b01,
        REG_NONE   = 2'b10
    } rsc_reg_e;

    typedef enum logic [1:0] {
        LN_RESET    = 2'b00,
        LN_CAL      = 2'b01,
        LN_REF_LOCK = 2'b10,
        LN_LTD      = 2'b11
    } rsc_lane_e;

    typedef struct packed {
        logic cal_busy;
        logic locked;
        logic pcs_stat;
        logic pma_stat;
    } rsc_lane_stat_s;
endpackage

// ==== verification/rsc_rst_ctrl_model.sv ====
// Partner model: lane reset controller, link clock source and reconfiguration source
`timescale 1ns/1ps
module rsc_rst_ctrl_model #(
    parameter logic [69:0] PAT = 70'h0
) (
    input  wire logic         aclk,            // Clock
    input  wire logic [3:0]   ana_cmd,         // PMA reset request
    input  wire logic [3:0]   pcs_cmd,         // PCS reset request
    input  wire logic [3:0]   cal_busy,        // Calibration busy seen
    output logic      [3:0]   analog_reset,    // PMA reset
    output logic      [3:0]   pcs_reset,       // PCS reset
    output logic      [3:0]   serial_p,        // Serial data +
    output logic      [3:0]   serial_n,        // Serial data -
    output logic              link_clk_in,     // Link clock
    output logic      [279:0] reconfig_bus_in  // Reconfig drive
);
    logic [2:0] div_r;
    initial begin
        analog_reset = '1;
        pcs_reset    = '1;
        serial_p     = '0;
        div_r        = 3'h0;
    end
    // PCS is kept in reset while the lane calibrates, as a real controller sequences it
    always @(posedge aclk) begin
        analog_reset <= ana_cmd;
        pcs_reset    <= pcs_cmd | ana_cmd | cal_busy;
        serial_p     <= ~serial_p;
        div_r        <= div_r + 3'h1;
    end
    assign serial_n        = ~serial_p;
    // Steady divider, never a lane clock, so the link rate is fixed
    assign link_clk_in     = div_r[2];
    assign reconfig_bus_in = {4{PAT}};
endmodule

// ==== verification/test_rsc_rx_clk_rst.sv ====
// Self-checking bench for the receiver clock, reset and status block
`timescale 1ns/1ps
module test_rsc_rx_clk_rst;
    localparam logic [69:0] PAT = 70'h2a_5a5a_5a5a_5a5a_5a5a;
    logic         aclk = 1'b0, aresetn = 1'b0, link_rst_n = 1'b0;
    logic [31:0]  s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0]   s_axi_wstrb = '0, ana_cmd = '1, pcs_cmd = '1;
    logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic         link_clk_in, link_rx_rst_n;
    logic [3:0]   serial_p, serial_n, rec_clk, pcs_reset, analog_reset;
    logic [3:0]   pcs_reset_stat, pma_reset_stat, lock_to_data, cal_busy;
    logic [279:0] reconfig_bus_in;
    logic [183:0] reconfig_bus_out;
    int           err_count = 0;
    int           compares = 0;

    always #25 aclk = ~aclk;

    rsc_rx_clk_rst u_rsc_rx_clk_rst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .link_clk_in, .link_rst_n, .link_rx_rst_n, .serial_p, .serial_n, .rec_clk,
        .pcs_reset, .analog_reset, .pcs_reset_stat, .pma_reset_stat, .lock_to_data,
        .cal_busy, .reconfig_bus_in, .reconfig_bus_out);

    rsc_rst_ctrl_model #(.PAT(PAT)) u_rsc_rst_ctrl_model (.aclk, .ana_cmd, .pcs_cmd,
        .cal_busy, .analog_reset, .pcs_reset, .serial_p, .serial_n, .link_clk_in,
        .reconfig_bus_in);

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic t_init();
        logic [1:0]  r;
        logic [31:0] d;
        chk("link_rx_rst_n", 32'h0, link_rx_rst_n);
        chk("pma_reset_stat", 32'hf, pma_reset_stat);
        rd(rsc_pkg::CTRL_OFFSET, d, r);
        chk("ctrl reset", 32'h0000_000f, d);
        rd(32'h0000_0010, d, r);
        chk("unmapped rresp", rsc_pkg::RESP_SLVERR, r);
        wr(32'h0000_0010, 32'h0, 4'hf, r);
        chk("unmapped bresp", rsc_pkg::RESP_SLVERR, r);
        wr(rsc_pkg::STATUS_OFFSET, 32'hffff_ffff, 4'hf, r);
        chk("status write resp", rsc_pkg::RESP_OKAY, r);
    endtask

    task automatic t_bringup();
        int bsy, lat, n;
        bsy = 0;
        lat = 0;
        n = 0;
        ana_cmd <= 4'h0;
        pcs_cmd <= 4'h0;
        link_rst_n <= 1'b1;
        while (lock_to_data !== 4'hf && n < 300) begin
            @(posedge aclk);
            n++;
            if (cal_busy[0] === 1'b1) bsy++;
            else if (bsy > 0 && lock_to_data[0] !== 1'b1) lat++;
            if ((rec_clk & ~lock_to_data) !== 4'h0) chk("rec_clk unlocked", 32'h0, rec_clk);
            if (lock_to_data !== 4'hf) chk("link held", 32'h0, link_rx_rst_n);
        end
        chk("busy cycles", rsc_pkg::CAL_CYCLES, bsy);
        chk("lock delay", rsc_pkg::LOCK_EDGES, lat);
        chk("pma stat clear", 32'h0, pma_reset_stat);
        repeat (3) @(posedge aclk);
        chk("link up", 32'h1, link_rx_rst_n);
        chk("rcfg echo", PAT[31:0], reconfig_bus_out[31:0]);
        chk("rcfg lock bit", 32'h1, reconfig_bus_out[44]);
    endtask

    // Window of 128 cycles is a whole number of link periods, so counts are exact
    task automatic t_clk(input logic pd);
        logic [1:0] r;
        int         nl, nr;
        logic       pl, pr;
        wr(rsc_pkg::CTRL_OFFSET, {23'h0, pd, 8'h0f}, 4'h3, r);
        nl = 0;
        nr = 0;
        pl = link_clk_in;
        pr = rec_clk[0];
        repeat (128) begin
            @(posedge aclk);
            if (link_clk_in && !pl) nl++;
            if (rec_clk[0] && !pr) nr++;
            pl = link_clk_in;
            pr = rec_clk[0];
        end
        chk("rec_clk rises", pd ? nl / 2 : nl, nr);
    endtask

    task automatic t_pcs();
        pcs_cmd <= 4'h2;
        repeat (4) @(posedge aclk);
        chk("pcs stat", 32'h2, pcs_reset_stat);
        chk("pcs word held", 32'h0, reconfig_bus_out[87:80]);
        chk("link drop", 32'h0, link_rx_rst_n);
        pcs_cmd <= 4'h0;
        repeat (4) @(posedge aclk);
        chk("link back", 32'h1, link_rx_rst_n);
    endtask

    task automatic t_dis();
        logic [1:0]  r;
        logic [31:0] d;
        wr(rsc_pkg::CTRL_OFFSET, 32'h0000_0003, 4'h1, r);
        ana_cmd <= 4'h4;
        repeat (40) @(posedge aclk);
        chk("pma stat", 32'h4, pma_reset_stat);
        chk("lock lane 2", 32'hb, lock_to_data);
        chk("busy in reset", 32'h0, cal_busy);
        chk("link kept", 32'h1, link_rx_rst_n);
        rd(rsc_pkg::STATUS_OFFSET, d, r);
        chk("status", 32'h0001_440b, d);
        rd(rsc_pkg::CTRL_OFFSET, d, r);
        chk("ctrl byte 0 only", 32'h0000_0103, d);
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #(rsc_pkg::CLK_PERIOD_NS * 5000);
        err_count++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        t_init();
        t_bringup();
        t_clk(1'b0);
        t_clk(1'b1);
        t_pcs();
        t_dis();
        link_rst_n <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("link reset", 32'h0, link_rx_rst_n);
        test_done();
    end
endmodule
